// File: logic/cfm_pkg.sv
package cfm_pkg;
	// Frame field values
	localparam logic [1:0] ST_CODE     = 2'h0;
	localparam logic [1:0] OP_ADDR     = 2'h0;
	localparam logic [1:0] OP_WRITE    = 2'h1;
	localparam logic [1:0] OP_READ_INC = 2'h2;
	localparam logic [1:0] OP_READ     = 2'h3;
	localparam logic [1:0] TA_WRITE    = 2'h2;
	localparam int         PRE_LEN     = 32;
	localparam int         FIELD_BITS  = 14;
	localparam int         DATA_BITS   = 16;
	// Device addresses
	localparam logic [4:0] DEV_MACSGMII = 5'h00;
	localparam logic [4:0] DEV_PMA      = 5'h01;
	localparam logic [4:0] DEV_PCS      = 5'h03;
	localparam logic [4:0] DEV_AN       = 5'h07;
	localparam logic [4:0] DEV_VEND     = 5'h1e;
	// Register offsets
	localparam logic [15:0] PMA_CTRL_OFS  = 16'h0000;
	localparam logic [15:0] PMA_STAT_OFS  = 16'h0001;
	localparam logic [15:0] PMA_IDL_OFS   = 16'h0002;
	localparam logic [15:0] PMA_IDH_OFS   = 16'h0003;
	localparam logic [15:0] PMA_PTR_OFS   = 16'h4110;
	localparam logic [15:0] PCS_PTR_OFS   = 16'h4111;
	localparam logic [15:0] AN_PTR_OFS    = 16'h4113;
	// Pointer values
	localparam logic [15:0] PTR_MAC       = 16'h2004;
	localparam logic [15:0] PTR_LINE      = 16'h0001;
	localparam logic [15:0] PTR_AN_LINE   = 16'h1002;
	// Control 1 fields
	localparam int CTRL_RESET_BIT = 15;
	localparam int CTRL_SPD0_BIT  = 13;
	localparam int CTRL_LOWPWR_BIT = 11;
	localparam int CTRL_SPD1_BIT  = 6;
	localparam int CTRL_PMA_LOOP_ENABLE_BIT  = 0;
	localparam logic [15:0] CTRL_RST_VAL = 16'h0000;
	localparam logic [15:0] CTRL_RW_MASK = 16'h7ffe;
	// Status 1 fields
	localparam int STAT_FAULT_BIT = 7;
	localparam int STAT_LINK_BIT  = 2;
	localparam int STAT_LPCAP_BIT = 1;
	// Address register fields
	localparam int ADDR_VEND_BIT  = 15;
	// Speed decode
	localparam logic [3:0] HR_5G   = 4'h7;
	localparam logic [3:0] HR_2G5  = 4'h6;
	localparam logic [3:0] HR_10G  = 4'h0;
	typedef enum logic [2:0] {
		SPD_NONE = 3'h0, SPD_100M = 3'h1, SPD_1G = 3'h2,
		SPD_2G5 = 3'h3, SPD_5G = 3'h4, SPD_10G = 3'h5
	} cfm_speed_t;
	// Identifier words (arbitrary values)
	localparam logic [15:0] IDENT_LOW_DEF  = 16'h1234;
	localparam logic [15:0] IDENT_HIGH_DEF = 16'h5678;
	// Controller command registers
	localparam logic [2:0] HC_CMD_OFS  = 3'h0;
	localparam logic [2:0] HC_DATA_OFS = 3'h1;
	localparam logic [2:0] HC_STAT_OFS = 3'h2;
	localparam logic [2:0] HC_RDAT_OFS = 3'h3;
	localparam logic [7:0] MDC_HALF_DIV = 8'h04;
endpackage : cfm_pkg

// File: logic/cfm_mdio_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfm_mdio_if;
	logic mdc;
	logic mdio_host_o;
	logic mdio_host_oe;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	wire  mdio_line = (mdio_host_oe ? mdio_host_o : 1'b1)
		& (mdio_dev_oe ? mdio_dev_o : 1'b1);
	modport host (output mdc, output mdio_host_o, output mdio_host_oe, input mdio_line);
	modport dev (input mdc, output mdio_dev_o, output mdio_dev_oe, input mdio_line);
endinterface : cfm_mdio_if
`default_nettype wire

// File: logic/cfm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising edge flag
module cfm_sync (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} cfm_sync_st_t;
	cfm_sync_st_t st_reg, st_next;
	// Shift chain
	always_comb begin
		st_next = '{s1: din, s2: st_reg.s1, s3: st_reg.s2};
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end
	assign dout = st_reg.s2;
	assign rise = st_reg.s2 & ~st_reg.s3;
endmodule : cfm_sync
`default_nettype wire

// File: logic/cfm_dev.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Port address strap caught at reset release
// - Act only when frame port matches
// - Controller clocks at most 25 MHz
// - Data sampled on management clock rising
// - Need 32 ones before start
// - Start 00, opcode selects address/read/write
// - Read-increment advances stored address afterwards
// - Port then device address, MSB first
// - Controller drives 10 in write turnaround
// - Read turnaround: release, then device drives 0
// - Sixteen data bits MSB first
// - Line released outside frames
// - Bit 15 picks IEEE or chip space
// - PMA pointer 0x2004 routes to MAC side
// - Line pointer values route to copper
// - Pointers reset to line side
// - Device zero only with MAC side
// - Speed bits decode to rate
// - Control reset, low power, loopback bits
// - Link status latches low until read
// - Software keeps reserved bits default
// - Two read-only identifier words
module cfm_dev (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	cfm_mdio_if.dev         mdio,
	input  wire logic [4:0] port_strap,
	input  wire logic       link_up,
	input  wire logic       fault_in,
	output logic            pma_reset_pulse,
	output logic            power_save_bit,
	output logic            pma_loop_enable,
	output logic            mac_side_sel,
	output cfm_pkg::cfm_speed_t speed_sel
);
	typedef enum logic [4:0] {
		S_PRE  = 5'b00001,
		S_HDR  = 5'b00010,
		S_TA   = 5'b00100,
		S_DATA = 5'b01000,
		S_SKIP = 5'b10000
	} cfm_dst_t;
	typedef struct packed {
		cfm_dst_t    fsm;
		logic [5:0]  ones;
		logic [4:0]  cnt;
		logic [13:0] hdr;
		logic [15:0] sh;
		logic [4:0]  port;
		logic        strapped;
		logic        drv;
		logic        dout;
		logic [15:0] adr_pma;
		logic [15:0] adr_pcs;
		logic [15:0] adr_an;
		logic [15:0] adr_vend;
		logic [15:0] adr_zero;
		logic [15:0] ctrl;
		logic        link_ll;
		logic [15:0] ptr_pma;
		logic [15:0] ptr_pcs;
		logic [15:0] ptr_an;
		logic        rst_pulse;
	} cfm_dev_st_t;
	cfm_dev_st_t st_reg, st_next;
	logic        mdc_rise;
	logic        din;
	logic [4:0]  f_port, f_dev;
	logic [1:0]  f_op;
	logic        hit;
	logic [15:0] cur_adr;
	logic [15:0] rd_val;
	logic [15:0] wr_val;
	cfm_sync u_mdc (.core_clk(core_clk), .rst_n(rst_n), .din(mdio.mdc),
		.dout(), .rise(mdc_rise));
	cfm_sync u_dat (.core_clk(core_clk), .rst_n(rst_n), .din(mdio.mdio_line),
		.dout(din), .rise());
	// Stored address lookup per device
	function automatic logic [15:0] adr_of(input cfm_dev_st_t s, input logic [4:0] d);
		unique case (d)
			cfm_pkg::DEV_PMA:  adr_of = s.adr_pma;
			cfm_pkg::DEV_PCS:  adr_of = s.adr_pcs;
			cfm_pkg::DEV_AN:   adr_of = s.adr_an;
			cfm_pkg::DEV_VEND: adr_of = s.adr_vend;
			default:           adr_of = s.adr_zero;
		endcase
	endfunction : adr_of
	// Header fields, port first
	assign f_op   = st_reg.hdr[11:10];
	assign f_port = st_reg.hdr[9:5];
	assign f_dev  = st_reg.hdr[4:0];
	assign mac_side_sel = (st_reg.ptr_pma == cfm_pkg::PTR_MAC);
	// Device answers when port matches and device is mapped
	assign hit = (f_port == st_reg.port)
		&& (f_dev != cfm_pkg::DEV_MACSGMII || mac_side_sel);
	assign cur_adr = adr_of(st_reg, f_dev);
	assign wr_val  = {st_reg.sh[14:0], din};
	// Read mux; chip-space and MAC-side reads return zero
	always_comb begin
		rd_val = 16'h0000;
		if (f_dev == cfm_pkg::DEV_PMA && !cur_adr[cfm_pkg::ADDR_VEND_BIT] && !mac_side_sel) begin
			unique case (cur_adr)
				cfm_pkg::PMA_CTRL_OFS: rd_val = st_reg.ctrl;
				cfm_pkg::PMA_STAT_OFS: begin
					rd_val[cfm_pkg::STAT_FAULT_BIT] = fault_in;
					rd_val[cfm_pkg::STAT_LINK_BIT]  = st_reg.link_ll;
					rd_val[cfm_pkg::STAT_LPCAP_BIT] = 1'b1;
				end
				cfm_pkg::PMA_IDL_OFS: rd_val = cfm_pkg::IDENT_LOW_DEF;
				cfm_pkg::PMA_IDH_OFS: rd_val = cfm_pkg::IDENT_HIGH_DEF;
				default: rd_val = 16'h0000;
			endcase
		end else if (f_dev == cfm_pkg::DEV_VEND) begin
			unique case (cur_adr)
				cfm_pkg::PMA_PTR_OFS: rd_val = st_reg.ptr_pma;
				cfm_pkg::PCS_PTR_OFS: rd_val = st_reg.ptr_pcs;
				cfm_pkg::AN_PTR_OFS:  rd_val = st_reg.ptr_an;
				default: rd_val = 16'h0000;
			endcase
		end
	end

	// Frame engine, advanced on each management clock rise
	always_comb begin
		st_next = st_reg;
		st_next.rst_pulse = 1'b0;
		if (!st_reg.strapped) begin
			st_next.port = port_strap;
			st_next.strapped = 1'b1;
		end
		if (!link_up) st_next.link_ll = 1'b0;
		// Self-clearing reset bit
		if (st_reg.ctrl[cfm_pkg::CTRL_RESET_BIT]) begin
			st_next.ctrl[cfm_pkg::CTRL_RESET_BIT] = 1'b0;
			st_next.rst_pulse = 1'b1;
		end
		if (mdc_rise) begin
			unique case (st_reg.fsm)
				S_PRE: begin
					st_next.drv = 1'b0;
					if (din) begin
						if (st_reg.ones != 6'd32) st_next.ones = st_reg.ones + 6'd1;
					end else begin
						st_next.ones = 6'd0;
						// First start bit; fewer ones spoil the frame
						st_next.fsm = (st_reg.ones == 6'd32) ? S_HDR : S_SKIP;
						st_next.cnt = 5'd0;
						st_next.hdr = 14'h0000;
					end
				end
				S_HDR: begin
					// Start bit 2, op, port, device
					st_next.hdr = {st_reg.hdr[12:0], din};
					st_next.cnt = st_reg.cnt + 5'd1;
					if (st_reg.cnt == 5'd0 && din) st_next.fsm = S_SKIP;
					if (st_reg.cnt == 5'd12) begin
						st_next.fsm = S_TA;
						st_next.cnt = 5'd0;
					end
				end
				S_TA: begin
					st_next.cnt = st_reg.cnt + 5'd1;
					// Read turnaround: idle, then drive zero
					if (st_reg.cnt == 5'd0 && f_op[1] && hit) begin
						st_next.drv  = 1'b1;
						st_next.dout = 1'b0;
						st_next.sh   = rd_val;
					end
					if (st_reg.cnt == 5'd1) begin
						st_next.fsm = S_DATA;
						st_next.cnt = 5'd0;
						if (st_reg.drv) begin
							st_next.dout = st_reg.sh[15];
							st_next.sh = {st_reg.sh[14:0], 1'b0};
						end
					end
				end
				S_DATA: begin
					st_next.cnt = st_reg.cnt + 5'd1;
					if (st_reg.drv) begin
						st_next.dout = st_reg.sh[15];
						st_next.sh = {st_reg.sh[14:0], 1'b0};
					end else begin
						st_next.sh = wr_val;
					end
					if (st_reg.cnt == 5'd15) begin
						st_next.fsm = S_PRE;
						st_next.drv = 1'b0;
						st_next.ones = din ? 6'd1 : 6'd0;
						if (hit && f_op == cfm_pkg::OP_ADDR) begin
							unique case (f_dev)
								cfm_pkg::DEV_PMA:  st_next.adr_pma  = wr_val;
								cfm_pkg::DEV_PCS:  st_next.adr_pcs  = wr_val;
								cfm_pkg::DEV_AN:   st_next.adr_an   = wr_val;
								cfm_pkg::DEV_VEND: st_next.adr_vend = wr_val;
								default:           st_next.adr_zero = wr_val;
							endcase
						end
						if (hit && f_op == cfm_pkg::OP_READ_INC) begin
							unique case (f_dev)
								cfm_pkg::DEV_PMA:  st_next.adr_pma  = cur_adr + 16'h0001;
								cfm_pkg::DEV_PCS:  st_next.adr_pcs  = cur_adr + 16'h0001;
								cfm_pkg::DEV_AN:   st_next.adr_an   = cur_adr + 16'h0001;
								cfm_pkg::DEV_VEND: st_next.adr_vend = cur_adr + 16'h0001;
								default:           st_next.adr_zero = cur_adr + 16'h0001;
							endcase
						end
						// Reading status re-arms the latched-low link bit
						if (hit && f_op[1] && f_dev == cfm_pkg::DEV_PMA && !mac_side_sel
							&& cur_adr == cfm_pkg::PMA_STAT_OFS)
							st_next.link_ll = link_up;
						if (hit && f_op == cfm_pkg::OP_WRITE) begin
							if (f_dev == cfm_pkg::DEV_PMA && !mac_side_sel
								&& cur_adr == cfm_pkg::PMA_CTRL_OFS)
								st_next.ctrl = wr_val;
							if (f_dev == cfm_pkg::DEV_VEND) begin
								if (cur_adr == cfm_pkg::PMA_PTR_OFS) st_next.ptr_pma = wr_val;
								if (cur_adr == cfm_pkg::PCS_PTR_OFS) st_next.ptr_pcs = wr_val;
								if (cur_adr == cfm_pkg::AN_PTR_OFS)  st_next.ptr_an  = wr_val;
							end
						end
					end
				end
				S_SKIP: begin
					// Wait for idle ones before hunting again
					st_next.ones = din ? st_reg.ones + 6'd1 : 6'd0;
					if (din) st_next.fsm = S_PRE;
				end
				default: st_next.fsm = S_PRE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg          <= '0;
			st_reg.fsm      <= S_PRE;
			st_reg.ctrl     <= cfm_pkg::CTRL_RST_VAL;
			st_reg.ptr_pma  <= cfm_pkg::PTR_LINE;
			st_reg.ptr_pcs  <= cfm_pkg::PTR_LINE;
			st_reg.ptr_an   <= cfm_pkg::PTR_AN_LINE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Speed decode of control bits 6 and 13
	always_comb begin
		unique case ({st_reg.ctrl[cfm_pkg::CTRL_SPD1_BIT], st_reg.ctrl[cfm_pkg::CTRL_SPD0_BIT]})
			2'b11: begin
				unique case (st_reg.ctrl[5:2])
					cfm_pkg::HR_5G:  speed_sel = cfm_pkg::SPD_5G;
					cfm_pkg::HR_2G5: speed_sel = cfm_pkg::SPD_2G5;
					cfm_pkg::HR_10G: speed_sel = cfm_pkg::SPD_10G;
					default:         speed_sel = cfm_pkg::SPD_NONE;
				endcase
			end
			2'b10:   speed_sel = cfm_pkg::SPD_1G;
			2'b01:   speed_sel = cfm_pkg::SPD_100M;
			default: speed_sel = cfm_pkg::SPD_NONE;
		endcase
	end

	assign mdio.mdio_dev_o  = st_reg.dout;
	assign mdio.mdio_dev_oe = st_reg.drv;
	assign pma_reset_pulse  = st_reg.rst_pulse;
	assign power_save_bit   = st_reg.ctrl[cfm_pkg::CTRL_LOWPWR_BIT];
	assign pma_loop_enable  = st_reg.ctrl[cfm_pkg::CTRL_PMA_LOOP_ENABLE_BIT];
endmodule : cfm_dev
`default_nettype wire

// File: logic/cfm_host.sv
`timescale 1ns/1ps
`default_nettype none
// Station controller: one Clause 45 frame per command
module cfm_host (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	cfm_mdio_if.host         mdio,
	input  wire logic [2:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata
);
	typedef struct packed {
		logic        busy;
		logic [7:0]  div;
		logic        mdc;
		logic [6:0]  bitn;
		logic [63:0] frame;
		logic [1:0]  op;
		logic [15:0] cmd;
		logic [15:0] data;
		logic [15:0] rdat;
		logic [31:0] rdata;
	} cfm_host_st_t;
	cfm_host_st_t st_reg, st_next;
	logic din;
	cfm_sync u_din (.core_clk(core_clk), .rst_n(rst_n), .din(mdio.mdio_line),
		.dout(din), .rise());

	// Command: [1:0] op, [6:2] port, [11:7] device; data register holds payload
	always_comb begin
		st_next = st_reg;
		st_next.rdata = 32'h0;
		if (rd) begin
			unique case (addr)
				cfm_pkg::HC_CMD_OFS:  st_next.rdata = {16'h0, st_reg.cmd};
				cfm_pkg::HC_DATA_OFS: st_next.rdata = {16'h0, st_reg.data};
				cfm_pkg::HC_STAT_OFS: st_next.rdata = {31'h0, st_reg.busy};
				cfm_pkg::HC_RDAT_OFS: st_next.rdata = {16'h0, st_reg.rdat};
				default:              st_next.rdata = 32'h0;
			endcase
		end
		if (wr && addr == cfm_pkg::HC_DATA_OFS) st_next.data = wdata[15:0];
		if (wr && addr == cfm_pkg::HC_CMD_OFS && !st_reg.busy) begin
			st_next.cmd  = wdata[15:0];
			st_next.op   = wdata[1:0];
			st_next.busy = 1'b1;
			st_next.bitn = 7'd0;
			st_next.div  = 8'h00;
			st_next.frame = {32'hffffffff, cfm_pkg::ST_CODE, wdata[1:0], wdata[6:2],
				wdata[11:7], cfm_pkg::TA_WRITE, st_reg.data};
		end
		// Clock divider and bit shifter
		if (st_reg.busy) begin
			st_next.div = st_reg.div + 8'h01;
			if (st_reg.div == cfm_pkg::MDC_HALF_DIV) begin
				st_next.div = 8'h00;
				st_next.mdc = ~st_reg.mdc;
				if (!st_reg.mdc) begin
					// Rising edge: capture read bit
					if (st_reg.bitn >= 7'd48) st_next.rdat = {st_reg.rdat[14:0], din};
				end else begin
					st_next.frame = {st_reg.frame[62:0], 1'b1};
					st_next.bitn  = st_reg.bitn + 7'd1;
					if (st_reg.bitn == 7'd63) st_next.busy = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Release the line in read turnaround and data
	assign mdio.mdc          = st_reg.mdc;
	assign mdio.mdio_host_o  = st_reg.frame[63];
	assign mdio.mdio_host_oe = st_reg.busy
		&& !(st_reg.op[1] && st_reg.bitn >= 7'd46);
	assign rdata = st_reg.rdata;
endmodule : cfm_host
`default_nettype wire

// File: testbench/cfm_mdio_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Wire-level checks on the link between the two ends
module cfm_mdio_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic mdio_host_o,
	input wire logic mdio_host_oe,
	input wire logic mdio_dev_o,
	input wire logic mdio_dev_oe,
	input wire logic mdio_line
);
	logic [8:0] oe_cnt_reg;
	logic [8:0] pre_cnt_reg;
	logic       seen0_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Counts device drive length and leading ones of a frame
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_cnt_reg  <= 9'h000;
			pre_cnt_reg <= 9'h000;
			seen0_reg   <= 1'b0;
		end else begin
			oe_cnt_reg <= mdio_dev_oe ? oe_cnt_reg + 9'h001 : 9'h000;
			if (!mdio_host_oe) begin
				pre_cnt_reg <= 9'h000;
				seen0_reg   <= 1'b0;
			end else if (!seen0_reg && mdio_host_o) begin
				pre_cnt_reg <= pre_cnt_reg + 9'h001;
			end else if (!mdio_host_o) begin
				seen0_reg <= 1'b1;
			end
		end
	end

	property p_no_clash;
		mdio_host_oe |-> !mdio_dev_oe;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive");

	property p_ta_zero;
		$rose(mdio_dev_oe) |-> !mdio_line;
	endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");

	property p_ta_release;
		$fell(mdio_host_oe) |-> (!mdio_dev_oe) [*6];
	endproperty
	a_ta_release: assert property (p_ta_release) else $error("early drive");

	property p_read_len;
		$fell(mdio_dev_oe) |-> oe_cnt_reg >= 9'd160 && oe_cnt_reg <= 9'd180;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read drive length");

	property p_dev_shift;
		mdio_dev_oe && $past(mdio_dev_oe) && $changed(mdio_dev_o) |-> mdc;
	endproperty
	a_dev_shift: assert property (p_dev_shift) else $error("read bit moved late");

	property p_preamble;
		mdio_host_oe && !seen0_reg && !mdio_host_o |-> pre_cnt_reg >= 9'd300 && pre_cnt_reg <= 9'd330;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble length");

	property p_mdc_high;
		$rose(mdc) |-> mdc [*5];
	endproperty
	a_mdc_high: assert property (p_mdc_high) else $error("clock high too short");

	property p_setup;
		$rose(mdc) && $past(mdio_host_oe) |-> $stable(mdio_host_o);
	endproperty
	a_setup: assert property (p_setup) else $error("data moved at rise");
endmodule : cfm_mdio_checker
`default_nettype wire

// File: testbench/clause45_mgmt_slave_pma_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clause45_mgmt_slave_pma_regs_tb;
	logic                core_clk = 1'b0;
	logic                rst_n    = 1'b0;
	logic [2:0]          addr     = 3'h0;
	logic [31:0]         wdata    = 32'h0;
	logic                wr       = 1'b0;
	logic                rd       = 1'b0;
	logic [4:0]          strap    = 5'h00;
	logic                link_up  = 1'b1;
	logic                fault_in = 1'b0;
	logic [31:0]         rdata;
	logic                rst_pulse;
	logic                psave;
	logic                loop_en;
	logic                mac_sel;
	cfm_pkg::cfm_speed_t speed;
	logic [31:0]         seed = 32'h3fb223d2;
	logic [4:0]          pt;
	logic [15:0]         rd_val;
	logic [15:0]         cw;
	logic [0:5][15:0]    cw_tab = {16'h205c, 16'h2058, 16'h2040, 16'h0040, 16'h2000, 16'h0801};
	int                  miscompares = 0;
	int                  checks_done = 0;
	int                  pulses = 0;

	cfm_mdio_if cfm_mdio_if_inst ();
	cfm_host cfm_host_inst (.core_clk(core_clk), .rst_n(rst_n), .mdio(cfm_mdio_if_inst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	cfm_dev cfm_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .mdio(cfm_mdio_if_inst),
		.port_strap(strap), .link_up(link_up), .fault_in(fault_in), .pma_reset_pulse(rst_pulse),
		.power_save_bit(psave), .pma_loop_enable(loop_en), .mac_side_sel(mac_sel),
		.speed_sel(speed));
	cfm_mdio_checker cfm_mdio_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
		.mdc(cfm_mdio_if_inst.mdc), .mdio_host_o(cfm_mdio_if_inst.mdio_host_o),
		.mdio_host_oe(cfm_mdio_if_inst.mdio_host_oe), .mdio_dev_o(cfm_mdio_if_inst.mdio_dev_o),
		.mdio_dev_oe(cfm_mdio_if_inst.mdio_dev_oe), .mdio_line(cfm_mdio_if_inst.mdio_line));

	// Clock and reset pulse counter
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (rst_pulse === 1'b1) pulses++;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected rate from the two speed bits and the high rate field
	function automatic cfm_pkg::cfm_speed_t exp_spd(input logic [15:0] c);
		if ({c[6], c[13]} == 2'b10) return cfm_pkg::SPD_1G;
		if ({c[6], c[13]} == 2'b01) return cfm_pkg::SPD_100M;
		if ({c[6], c[13]} == 2'b00) return cfm_pkg::SPD_NONE;
		if (c[5:2] == 4'h7) return cfm_pkg::SPD_5G;
		if (c[5:2] == 4'h6) return cfm_pkg::SPD_2G5;
		if (c[5:2] == 4'h0) return cfm_pkg::SPD_10G;
		return cfm_pkg::SPD_NONE;
	endfunction : exp_spd

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// One strobe cycle; read data is taken in the following cycle
	task automatic bus(input logic [2:0] a, input logic [31:0] d, input logic w);
		@(posedge core_clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		@(posedge core_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask : bus

	// One frame through the controller, waiting on its busy flag
	task automatic frame(input logic [1:0] op, input logic [4:0] dv, input logic [15:0] d);
		int n;
		n = 0;
		bus(cfm_pkg::HC_DATA_OFS, {16'h0000, d}, 1'b1);
		bus(cfm_pkg::HC_CMD_OFS, {20'h00000, dv, pt, op}, 1'b1);
		do begin
			bus(cfm_pkg::HC_STAT_OFS, 32'h0, 1'b0);
			n++;
		end while (rdata[0] !== 1'b0 && n < 500);
		// A frame that never ends counts as a mismatch
		if (rdata[0] !== 1'b0) begin
			miscompares++;
			finish_test();
		end
		bus(cfm_pkg::HC_RDAT_OFS, 32'h0, 1'b0);
		rd_val = rdata[15:0];
	endtask : frame

	task automatic rchk(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] e);
		frame(cfm_pkg::OP_ADDR, dv, a);
		frame(cfm_pkg::OP_READ, dv, 16'h0000);
		chk(rd_val, e);
	endtask : rchk

	task automatic wreg(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] d);
		frame(cfm_pkg::OP_ADDR, dv, a);
		frame(cfm_pkg::OP_WRITE, dv, d);
	endtask : wreg

	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// Watchdog
	initial begin
		repeat (90000) @(posedge core_clk);
		miscompares++;
		finish_test();
	end

	// Main sequence
	initial begin
		seed = lfsr(seed);
		pt = seed[4:0];
		@(posedge core_clk);
		strap <= seed[4:0];
		@(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rchk(5'h01, 16'h0000, 16'h0000);
		rchk(5'h1e, 16'h4110, 16'h0001);
		rchk(5'h1e, 16'h4111, 16'h0001);
		rchk(5'h1e, 16'h4113, 16'h1002);
		rchk(5'h01, 16'h0002, cfm_pkg::IDENT_LOW_DEF);
		wreg(5'h01, 16'h0003, seed[15:0]);
		rchk(5'h01, 16'h0003, cfm_pkg::IDENT_HIGH_DEF);
		$display("test reset_values done");
		// Read with increment, and stored address per device
		frame(cfm_pkg::OP_ADDR, 5'h1e, 16'h4113);
		frame(cfm_pkg::OP_ADDR, 5'h01, 16'h0002);
		frame(cfm_pkg::OP_READ_INC, 5'h01, 16'h0000);
		chk(rd_val, cfm_pkg::IDENT_LOW_DEF);
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val, cfm_pkg::IDENT_HIGH_DEF);
		frame(cfm_pkg::OP_READ, 5'h1e, 16'h0000);
		chk(rd_val, 16'h1002);
		$display("test addressing done");
		// Frame for another port address must be ignored
		pt = strap ^ 5'h01;
		wreg(5'h01, 16'h0000, 16'h0801);
		pt = strap;
		chk(16'(loop_en), 16'h0000);
		rchk(5'h01, 16'h0000, 16'h0000);
		$display("test port_filter done");
		// Fixed speed codes, then random control words
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			cw = (i < 6) ? cw_tab[i] : (seed[15:0] & 16'h287d);
			frame(cfm_pkg::OP_WRITE, 5'h01, cw);
			chk(16'(speed), 16'(exp_spd(cw)));
			chk(16'({psave, loop_en}), 16'({cw[11], cw[0]}));
			frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
			chk(rd_val, cw);
		end
		rchk(5'h01, 16'h8000, 16'h0000);
		wreg(5'h01, 16'h0000, 16'h8000);
		chk(16'(pulses), 16'h0001);
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val, 16'h0000);
		$display("test control done");
		// Arm the latched-low link bit, then drop the link briefly
		frame(cfm_pkg::OP_ADDR, 5'h01, 16'h0001);
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val & 16'h0086, 16'h0002);
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val & 16'h0086, 16'h0006);
		@(posedge core_clk);
		link_up  <= 1'b0;
		fault_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		link_up <= 1'b1;
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val & 16'h0086, 16'h0082);
		frame(cfm_pkg::OP_READ, 5'h01, 16'h0000);
		chk(rd_val & 16'h0086, 16'h0086);
		$display("test link_status done");
		// Route to the MAC side, then back to the line side
		for (int i = 0; i < 2; i++) begin
			wreg(5'h1e, 16'h4110, (i != 0) ? 16'h0001 : 16'h2004);
			wreg(5'h1e, 16'h4111, (i != 0) ? 16'h0001 : 16'h2004);
			wreg(5'h1e, 16'h4113, (i != 0) ? 16'h1002 : 16'h2004);
			chk(16'(mac_sel), 16'(i == 0));
			rchk(5'h00, 16'h0000, (i != 0) ? 16'hffff : 16'h0000);
			rchk(5'h01, 16'h0002, (i != 0) ? cfm_pkg::IDENT_LOW_DEF : 16'h0000);
		end
		$display("test routing done");
		// Second reset: new strap taken, PMA pointer back to line side
		wreg(5'h1e, 16'h4110, 16'h2004);
		@(posedge core_clk);
		rst_n <= 1'b0;
		strap <= strap ^ 5'h15;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rchk(5'h1e, 16'h4110, 16'hffff);
		pt = strap;
		rchk(5'h1e, 16'h4110, 16'h0001);
		chk(16'(mac_sel), 16'h0000);
		$display("test second_reset done");
		finish_test();
	end
endmodule : clause45_mgmt_slave_pma_regs_tb
`default_nettype wire
